//--- jmf_multiframe.sv
// multiframe configuration, lmfc generation and apb registers
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// RL1 - the multiframe length in frames is at least ceil(17 / octets per frame).
// RL2 - frame octets follow resolution and packing, with the tabled multiframe lengths.
// RL3 - the advertised five-bit k field holds multiframe frames minus one.
// RL4 - the lmfc period equals one multiframe of k frames.
// RL5 - reset configuration is four per lane, 12-bit, serialisation 12, k of 3.
// RL6 - converters per lane (two, four, eight) are chosen by a software register.
// RL7 - the first converter's sample fills the first two octets of each frame.
// RL8 - each lane boosts drive on a bit transition, 16 levels of 0.25 ma.
// RL9 - software should enable boost at high lane rates (advice only).
// RL10 - a sync event clears the frame counter unless a forced initial count is set; the code loads the forced count only when it is below k, else clears to zero.
// RL11 - sysref is sampled on rising clock edges in subclass 1, sync rising in subclass 2.
// RL12 - no lmfc runs in subclass 0.
// RL13 - the frame counter runs 0 to k-1, wraps, and pulses on the wrap.
module jmf_multiframe #(
    parameter int LANES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sysref,
    input wire logic sync_n,
    input wire logic frame_tick,
    input wire logic bit_valid,
    input wire logic [LANES-1:0] serial_lane_output,
    input wire logic [15:0] first_sample,
    output logic [4:0] k_field,
    output logic [4:0] frame_octets,
    output logic [1:0] adc_per_lane,
    output logic [15:0] frame_head,
    output logic lmfc,
    output logic mf_boundary,
    output logic [LANES*4-1:0] boost_code
);
    import jmf_pkg::*;

    // ----------------------------------------
    // geometry lookup
    // ----------------------------------------
    function automatic jmf_geom_t geom_of(input jmf_pack_t pk, input jmf_res_t rs);
        jmf_geom_t g;
        logic [4:0] per;
        per = (rs == JMF_RES_12) ? 5'd3 : 5'd4; // two-per-lane octets
        g = '0;
        case (pk)
            JMF_PACK_2: g.octets = per; // RL2
            JMF_PACK_4: g.octets = (rs == JMF_RES_12) ? 5'd6 : ((rs == JMF_RES_14) ? 5'd7 : 5'd8);
            JMF_PACK_8: g.octets = (rs == JMF_RES_12) ? 5'd12 : ((rs == JMF_RES_14) ? 5'd14 : 5'd16);
            default: g.octets = 5'd6;
        endcase
        // least frames so that frames*octets >= 17
        g.k_frames = 5'((JMF_MIN_MF_OCTETS + int'(g.octets) - 1) / int'(g.octets)); // RL1
        g.k_field = g.k_frames - 5'd1; // RL3
        return g;
    endfunction : geom_of

    // spare field code maps to the reset code, so a bad write never
    // leaves an undefined packing, resolution or subclass behind
    function automatic logic [1:0] code_or_rst(input logic [1:0] code, input logic [1:0] rst);
        logic [1:0] c;
        c = (code == JMF_CODE_SPARE) ? rst : code;
        return c;
    endfunction : code_or_rst

    // geometry of the reset configuration, for the registered outputs
    localparam jmf_geom_t GEOM_RST = geom_of(JMF_PACK_RST, JMF_RES_RST);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    jmf_pack_t pack_q, pack_d;
    jmf_res_t res_q, res_d;
    jmf_sub_t sub_q, sub_d;
    logic force_q, force_d;
    logic [4:0] init_q, init_d;
    logic [3:0] lvl_q, lvl_d;
    logic ben_q, ben_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;

    jmf_geom_t geom;
    logic access;

    // first access cycle only: registered pready masks the second one,
    // so a held access phase never commits twice
    assign geom = geom_of(pack_q, res_q);
    assign access = psel && penable && !ready_q;

    // ----------------------------------------
    // frame counter state
    // ----------------------------------------
    logic [4:0] cnt_q, cnt_d;
    logic lmfc_q, lmfc_d;
    logic bnd_q, bnd_d;
    logic sysref_q;
    logic sync_q;
    logic event_hit;
    logic [15:0] head_q, head_d;
    logic [4:0] kf_q, kf_d;
    logic [4:0] oct_q, oct_d;

    // apb slave: one wait state, pready on second access cycle
    always_comb begin
        pack_d = pack_q;
        res_d = res_q;
        sub_d = sub_q;
        force_d = force_q;
        init_d = init_q;
        lvl_d = lvl_q;
        ben_d = ben_q;
        rdata_d = rdata_q;
        ready_d = access;
        err_d = 1'b0;
        if (access) begin
            rdata_d = '0;
            case (paddr)
                JMF_OFF_CTRL: begin
                    if (pwrite) begin
                        // unsupported codes fall back to the reset value
                        pack_d = jmf_pack_t'(code_or_rst(pwdata[JMF_CTRL_PACK_LSB +: 2],
                            JMF_PACK_RST)); // RL6
                        res_d = jmf_res_t'(code_or_rst(pwdata[JMF_CTRL_RES_LSB +: 2],
                            JMF_RES_RST));
                        sub_d = jmf_sub_t'(code_or_rst(pwdata[JMF_CTRL_SUB_LSB +: 2],
                            JMF_SUB_RST));
                    end
                    rdata_d[JMF_CTRL_PACK_LSB +: 2] = pack_q;
                    rdata_d[JMF_CTRL_RES_LSB +: 2] = res_q;
                    rdata_d[JMF_CTRL_SUB_LSB +: 2] = sub_q;
                end
                JMF_OFF_LMFC: begin
                    if (pwrite) begin
                        init_d = pwdata[JMF_LMFC_INIT_LSB +: 5];
                        force_d = pwdata[JMF_LMFC_FORCE_BIT];
                    end
                    rdata_d[JMF_LMFC_INIT_LSB +: 5] = init_q;
                    rdata_d[JMF_LMFC_FORCE_BIT] = force_q;
                end
                JMF_OFF_BOOST: begin
                    if (pwrite) begin
                        lvl_d = pwdata[JMF_BOOST_LVL_LSB +: 4]; // RL8
                        ben_d = pwdata[JMF_BOOST_EN_BIT]; // RL9
                    end
                    rdata_d[JMF_BOOST_LVL_LSB +: 4] = lvl_q;
                    rdata_d[JMF_BOOST_EN_BIT] = ben_q;
                end
                JMF_OFF_STATUS: begin
                    // read-only view of live geometry and count
                    rdata_d[JMF_STAT_CNT_LSB +: 5] = cnt_q;
                    rdata_d[JMF_STAT_K_LSB +: 5] = geom.k_field;
                    rdata_d[JMF_STAT_OCT_LSB +: 5] = geom.octets;
                    rdata_d[JMF_STAT_SER_LSB +: 4] = JMF_SER_FACTOR_RST;
                end
                default: err_d = 1'b1;
            endcase
        end
    end

    // register file and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pack_q <= JMF_PACK_RST; // RL5
            res_q <= JMF_RES_RST; // RL5
            sub_q <= JMF_SUB_RST;
            force_q <= 1'b0;
            init_q <= JMF_LMFC_INIT_RST;
            lvl_q <= JMF_BOOST_RST;
            ben_q <= 1'b0;
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            pack_q <= pack_d;
            res_q <= res_d;
            sub_q <= sub_d;
            force_q <= force_d;
            init_q <= init_d;
            lvl_q <= lvl_d;
            ben_q <= ben_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    // ----------------------------------------
    // multiframe counter and lmfc
    // ----------------------------------------
    // sysref level rising and sync_n rising are taken on clock rising edges only
    always_comb begin
        case (sub_q)
            JMF_SUB_1: event_hit = sysref && !sysref_q; // RL11
            JMF_SUB_2: event_hit = sync_n && !sync_q; // RL11
            default: event_hit = 1'b0;
        endcase
    end

    // subclass 0 pins the counter; an event outranks a frame tick
    always_comb begin
        cnt_d = cnt_q;
        bnd_d = 1'b0;
        lmfc_d = lmfc_q;
        if (sub_q == JMF_SUB_0) begin
            cnt_d = '0; // RL12
            lmfc_d = 1'b0; // RL12
        end else if (event_hit) begin
            // forced count taken only when below k, else zero, so the wrap still occurs
            cnt_d = (force_q && init_q < geom.k_frames) ? init_q : 5'd0; // RL10
            lmfc_d = (cnt_d == 5'd0);
        end else if (frame_tick) begin
            if (cnt_q >= geom.k_frames - 5'd1) begin
                cnt_d = 5'd0; // RL13
                bnd_d = 1'b1; // RL13
                lmfc_d = 1'b1; // RL4
            end else begin
                cnt_d = cnt_q + 5'd1;
                lmfc_d = 1'b0;
            end
        end
    end

    // edge detectors rest at the idle pin levels: no false event after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            lmfc_q <= 1'b0;
            bnd_q <= 1'b0;
            sysref_q <= 1'b0;
            sync_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            lmfc_q <= lmfc_d;
            bnd_q <= bnd_d;
            sysref_q <= sysref;
            sync_q <= sync_n;
        end
    end

    // ----------------------------------------
    // registered geometry and frame head
    // ----------------------------------------
    // geometry held in flops so the pins never show the lookup settling
    always_comb begin
        kf_d = geom.k_field; // RL3
        oct_d = geom.octets; // RL2
        head_d = head_q;
        if (frame_tick) begin
            head_d = first_sample; // RL7
        end
    end

    // reset values follow the reset configuration's own geometry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kf_q <= GEOM_RST.k_field;
            oct_q <= GEOM_RST.octets;
            head_q <= '0;
        end else begin
            kf_q <= kf_d;
            oct_q <= oct_d;
            head_q <= head_d;
        end
    end

    // ----------------------------------------
    // lane boost
    // ----------------------------------------
    // level and enable come straight from the register file
    jmf_lane_boost #(
        .LANES(LANES)
    ) u_boost (
        .pclk(pclk),
        .presetn(presetn),
        .boost_en(ben_q),
        .transition_boost_level(lvl_q),
        .bit_valid(bit_valid),
        .serial_lane_output(serial_lane_output),
        .boost_code(boost_code)
    );

    // outputs straight from flops
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign k_field = kf_q;
    assign frame_octets = oct_q;
    assign adc_per_lane = pack_q;
    assign frame_head = head_q;
    assign lmfc = lmfc_q;
    assign mf_boundary = bnd_q;

endmodule : jmf_multiframe

`default_nettype wire

//--- jmf_pkg.sv
// package for the multiframe configuration block: register map, fields, constants
package jmf_pkg;

    // ----------------------------------------
    // register byte offsets on the apb bus
    // ----------------------------------------
    localparam logic [11:0] JMF_OFF_CTRL = 12'h000;
    localparam logic [11:0] JMF_OFF_LMFC = 12'h004;
    localparam logic [11:0] JMF_OFF_BOOST = 12'h008;
    localparam logic [11:0] JMF_OFF_STATUS = 12'h00C;

    // ----------------------------------------
    // control field positions
    // ----------------------------------------
    localparam int JMF_CTRL_PACK_LSB = 0;
    localparam int JMF_CTRL_RES_LSB = 2;
    localparam int JMF_CTRL_SUB_LSB = 4;
    localparam int JMF_LMFC_FORCE_BIT = 8;
    localparam int JMF_BOOST_EN_BIT = 4;
    localparam int JMF_LMFC_INIT_LSB = 0;
    localparam int JMF_BOOST_LVL_LSB = 0;

    // status word field positions
    localparam int JMF_STAT_CNT_LSB = 0;
    localparam int JMF_STAT_K_LSB = 8;
    localparam int JMF_STAT_OCT_LSB = 16;
    localparam int JMF_STAT_SER_LSB = 24;

    // spare two-bit field code, never a legal setting
    localparam logic [1:0] JMF_CODE_SPARE = 2'd3;

    // packing: converters per lane
    typedef enum logic [1:0] {
        JMF_PACK_2 = 2'd0,
        JMF_PACK_4 = 2'd1,
        JMF_PACK_8 = 2'd2
    } jmf_pack_t;

    // converter resolution code
    typedef enum logic [1:0] {
        JMF_RES_12 = 2'd0,
        JMF_RES_14 = 2'd1,
        JMF_RES_16 = 2'd2
    } jmf_res_t;

    // link subclass
    typedef enum logic [1:0] {
        JMF_SUB_0 = 2'd0,
        JMF_SUB_1 = 2'd1,
        JMF_SUB_2 = 2'd2
    } jmf_sub_t;

    // ----------------------------------------
    // reset values and limits
    // ----------------------------------------
    localparam jmf_pack_t JMF_PACK_RST = JMF_PACK_4;
    localparam jmf_res_t JMF_RES_RST = JMF_RES_12;
    localparam jmf_sub_t JMF_SUB_RST = JMF_SUB_1;
    localparam logic [3:0] JMF_SER_FACTOR_RST = 4'd12;
    localparam int JMF_MIN_MF_OCTETS = 17;
    localparam int JMF_BOOST_STEP_UA = 250;
    localparam logic [3:0] JMF_BOOST_RST = 4'h0;
    localparam logic [4:0] JMF_LMFC_INIT_RST = 5'h00;

    // frame geometry carried together
    typedef struct packed {
        logic [4:0] octets;
        logic [4:0] k_frames;
        logic [4:0] k_field;
    } jmf_geom_t;

endpackage : jmf_pkg

//--- jmf_lane_boost.sv
// per-lane transition boost: raises drive code when a bit differs from the last
`timescale 1ns/1ps
`default_nettype none

module jmf_lane_boost #(
    parameter int LANES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic boost_en,
    input wire logic [3:0] transition_boost_level,
    input wire logic bit_valid,
    input wire logic [LANES-1:0] serial_lane_output,
    output logic [LANES*4-1:0] boost_code
);
    import jmf_pkg::*;

    logic [LANES-1:0] prev_bit_q;
    logic [LANES-1:0] prev_bit_d;
    logic [LANES*4-1:0] code_q;
    logic [LANES*4-1:0] code_d;

    // ----------------------------------------
    // transition detect per lane
    // ----------------------------------------
    // level 0 means base current only; each step adds one boost increment
    always_comb begin
        prev_bit_d = prev_bit_q;
        code_d = code_q;
        if (bit_valid) begin
            prev_bit_d = serial_lane_output;
            for (int i = 0; i < LANES; i++) begin
                if (boost_en && (serial_lane_output[i] != prev_bit_q[i])) begin
                    code_d[i*4 +: 4] = transition_boost_level; // RL8
                end else begin
                    code_d[i*4 +: 4] = 4'h0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_bit_q <= '0;
            code_q <= '0;
        end else begin
            prev_bit_q <= prev_bit_d;
            code_q <= code_d;
        end
    end

    assign boost_code = code_q;

endmodule : jmf_lane_boost

`default_nettype wire

//--- jmf_props.sv
// assertion checker for the multiframe configuration block
`timescale 1ns/1ps
`default_nettype none
module jmf_props #(
    parameter int LANES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_tick,
    input wire logic [15:0] first_sample,
    input wire logic [15:0] frame_head,
    input wire logic [4:0] k_field,
    input wire logic [4:0] frame_octets,
    input wire logic lmfc,
    input wire logic mf_boundary,
    input wire logic bit_valid,
    input wire logic [LANES*4-1:0] boost_code
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // first access cycle, and a boundary pulse that drops again
    sequence acc_s; psel && penable && !pready; endsequence
    sequence wrap_s; mf_boundary ##1 !mf_boundary; endsequence
    apb_wait_a: assert property (acc_s |=> pready) else $error("no apb answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    k_min_a: assert property (({6'h0, k_field} + 11'h1) * frame_octets >= 11'h11
        && {6'h0, k_field} * frame_octets < 11'h11) else $error("k not minimal");
    wrap_lmfc_a: assert property (mf_boundary |-> lmfc) else $error("wrap off frame 0");
    wrap_pulse_a: assert property (mf_boundary |-> wrap_s) else $error("long wrap");
    head_cap_a: assert property (frame_tick |=> frame_head == $past(first_sample))
        else $error("head not captured");
    boost_hold_a: assert property (!bit_valid |=> $stable(boost_code))
        else $error("boost code moved");
endmodule : jmf_props
bind jmf_multiframe jmf_props #(.LANES(LANES)) u_props (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .frame_tick, .first_sample, .frame_head, .k_field, .frame_octets, .lmfc,
    .mf_boundary, .bit_valid, .boost_code);
`default_nettype wire

//--- jmf_far_end.sv
// far-end receiver model: frame ticks, sysref and sync pulses
`timescale 1ns/1ps
`default_nettype none
module jmf_far_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [1:0] gap,
    input wire logic fire_ref,
    input wire logic fire_syn,
    input wire logic [4:0] k_field,
    output logic frame_tick,
    output logic [5:0] rx_mf_len,
    output logic sysref,
    output logic sync_n
);
    logic [1:0] t_q;
    logic [1:0] r_q;
    logic [1:0] s_q;
    // receiver reads the field as frames minus one
    assign rx_mf_len = {1'b0, k_field} + 6'h01;
    // sysref rests low and sync rests high outside requests
    assign sysref = r_q != 2'h0;
    assign sync_n = s_q == 2'h0;
    // gap sets tick spacing, every cycle up to one in four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_q <= 2'h0;
            r_q <= 2'h0;
            s_q <= 2'h0;
            frame_tick <= 1'b0;
        end else begin
            frame_tick <= run && t_q == gap;
            t_q <= (run && t_q != gap) ? t_q + 2'h1 : 2'h0;
            r_q <= fire_ref ? 2'h2 : r_q - {1'b0, r_q != 2'h0};
            s_q <= fire_syn ? 2'h3 : s_q - {1'b0, s_q != 2'h0};
        end
    end
endmodule : jmf_far_end
`default_nettype wire

//--- test_jesd_multiframe_config.sv
// self-checking bench for the multiframe configuration block
`timescale 1ns/1ps
`default_nettype none
module test_jesd_multiframe_config;
    import jmf_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bit_valid = 0, run = 0;
    logic fire_ref = 0, fire_syn = 0, frc = 0, ben = 0, lm_ok = 0, m_bnd = 0, pr = 0, ps = 1;
    logic pready, pslverr, sysref, sync_n, frame_tick, lmfc, mf_boundary, er, ev;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0] gap = 0, pk = 1, rs = 0, sb = 1, adc_per_lane;
    logic [3:0] serial_lane_output = 0, lvl = 0, pb = 0;
    logic [15:0] first_sample = 0, m_head = 0, m_boost = 0, frame_head, boost_code;
    logic [4:0] k_field, frame_octets, ini = 0;
    logic [5:0] rx_mf_len;
    int err_count = 0, samples_checked = 0, cyc = 0, seed = 32'h6fbb, m_cnt = 0, i;
    always #4 pclk = ~pclk;
    jmf_multiframe #(.LANES(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sysref, .sync_n, .frame_tick, .bit_valid,
        .serial_lane_output, .first_sample, .k_field, .frame_octets, .adc_per_lane, .frame_head,
        .lmfc, .mf_boundary, .boost_code);
    jmf_far_end far (.pclk, .presetn, .run, .gap, .fire_ref, .fire_syn, .k_field, .frame_tick,
        .rx_mf_len, .sysref, .sync_n);
    function automatic int octs();
        return ((12 + 2 * rs) * (2 << pk) + 7) / 8;
    endfunction : octs
    function automatic int kf();
        return (16 + octs()) / octs();
    endfunction : kf
    // spare field code 3 reads back as the reset code
    function automatic logic [1:0] fb(input logic [1:0] c, input logic [1:0] r);
        return (c == 2'h3) ? r : c;
    endfunction : fb
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // ceiling well above the roughly 1200 cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    // reference model steps on pre-edge inputs, outputs compared once settled
    always @(posedge pclk) begin
        first_sample <= first_sample + 16'h9e37;
        ev = sb == 2'h1 ? sysref && !pr : sb == 2'h2 && sync_n && !ps;
        pr = sysref;
        ps = sync_n;
        if (presetn) begin
            m_bnd = 1'b0;
            if (sb == 2'h0) m_cnt = 0;
            else if (ev) begin
                m_cnt = (frc && ini < kf()) ? ini : 0;
                lm_ok = 1'b1;
            end else if (frame_tick) begin
                m_cnt = (m_cnt + 1) % kf();
                m_bnd = m_cnt == 0;
            end
            if (frame_tick) m_head = first_sample;
            for (i = 0; i < 4; i++)
                if (bit_valid) m_boost[4*i+:4] = (ben && serial_lane_output[i] != pb[i]) ? lvl : 0;
            if (bit_valid) pb = serial_lane_output;
            #1;
            check(mf_boundary, m_bnd);
            check(frame_head, m_head);
            check(boost_code, m_boost);
            if (sb == 2'h0 || lm_ok) check(lmfc, sb != 2'h0 && m_cnt == 0);
        end
    end
    // one apb transfer; the mirror follows a write from the answering edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check(n, 32'd2);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a == JMF_OFF_CTRL) {sb, rs, pk} <= {fb(d[5:4], JMF_SUB_RST),
            fb(d[3:2], JMF_RES_RST), fb(d[1:0], JMF_PACK_RST)};
        if (w && a == JMF_OFF_CTRL) lm_ok = 1'b0;
        if (w && a == JMF_OFF_LMFC) {frc, ini} <= {d[8], d[4:0]};
        if (w && a == JMF_OFF_BOOST) {ben, lvl} <= d[4:0];
    endtask : apb
    task automatic cfg(input logic [5:0] c);
        apb(1'b1, JMF_OFF_CTRL, {26'h0, c});
        repeat (2) @(posedge pclk);
        check(k_field, kf() - 1);
        check(rx_mf_len, kf());
        check(frame_octets, octs());
        check(adc_per_lane, pk);
    endtask : cfg
    // phase event, then frames at random spacing
    task automatic mf(input logic rf, input logic sf);
        @(posedge pclk);
        fire_ref <= rf;
        fire_syn <= sf;
        @(posedge pclk);
        fire_ref <= 1'b0;
        fire_syn <= 1'b0;
        repeat (6) @(posedge pclk);
        run <= 1'b1;
        repeat (48) @(posedge pclk) gap <= 2'($random(seed));
        run <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : mf
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check(k_field, kf() - 1);
        check(frame_octets, octs());
        check(adc_per_lane, pk);
        apb(1'b0, JMF_OFF_CTRL, 0);
        check(rd, 32'h0000_0011);
        apb(1'b1, JMF_OFF_CTRL, 32'h0000_003f);
        apb(1'b0, JMF_OFF_CTRL, 0);
        check(rd, 32'h0000_0011);
        apb(1'b1, JMF_OFF_STATUS, 32'hffff_ffff);
        apb(1'b0, JMF_OFF_STATUS, 0);
        check(rd, 32'h0c06_0200);
        apb(1'b0, 12'h010, 0);
        check(rd, 0);
        check(er, 1'b1);
        $display("register test done");
        mf(1'b1, 1'b0);
        for (int r = 0; r < 3; r++)
            for (int p = 0; p < 3; p++) begin
                cfg({2'h1, 2'(r), 2'(p)});
                mf(1'b1, 1'b0);
            end
        cfg(6'h25);
        mf(1'b1, 1'b0);
        mf(1'b0, 1'b1);
        apb(1'b1, JMF_OFF_LMFC, 32'h0000_0101);
        mf(1'b0, 1'b1);
        apb(1'b1, JMF_OFF_LMFC, 32'h0000_011f);
        apb(1'b0, JMF_OFF_LMFC, 0);
        check(rd, 32'h0000_011f);
        mf(1'b0, 1'b1);
        cfg(6'h05);
        mf(1'b1, 1'b1);
        $display("multiframe test done");
        for (int v = 0; v < 18; v++) begin
            apb(1'b1, JMF_OFF_BOOST, 32'(v + 16));
            repeat (3) @(posedge pclk) {bit_valid, serial_lane_output} <= {1'b1, 4'($random(seed))};
            @(posedge pclk);
            bit_valid <= 1'b0;
        end
        apb(1'b0, JMF_OFF_BOOST, 0);
        check(rd, 32'h0000_0001);
        $display("boost test done");
        end_sim();
    end
endmodule : test_jesd_multiframe_config
`default_nettype wire
